// File: uhcs_scheduler.v
// What this block does
// - pick one armed channel, check feasibility, run exactly one transaction
// - after each transaction, select the next armed channel in round-robin order and repeat
// - setting execute bit schedules the channel; transfer follows its configuration
// - single control channel serves all devices, one request at a time
// - bulk-only channel sequences command, data and status transport itself
// - status reported to firmware after every transaction
// - each channel has four flags and a result code
// - IN channel issues IN transactions whenever FIFO space is freed and frame time remains
// - OUT channel issues OUT transactions whenever FIFO holds valid data and frame time remains
// - SETUP runs only when enough frame time remains
// - SETUP data packet on the control channel is exactly eight bytes from setup registers
// - SETUP token goes to endpoint 0, then the data packet
// - SETUP acknowledge sets the acknowledged flag
// - no valid answer sets retry code, error flag, and retries
// - three consecutive failures clear execute and raise condition-changed in the same cycle
`include "uhcs_defines.vh"
module uhcs_scheduler (
    input wire i_ref_clk, // system clock
    input wire i_rst_n, // async reset, active low
    input wire i_ce, // clock enable
    input wire [5:0] i_exec_set, // pulse: firmware sets execute per channel
    input wire [5:0] i_exec_clr, // pulse: firmware clears execute per channel
    input wire [11:0] i_tt_sel, // transaction type per channel, 2 bits each
    input wire [6:0] i_func_addr, // control channel target address
    input wire [63:0] i_setup_bytes, // setup packet bytes, byte 0 in low bits
    input wire [5:0] i_fifo_ready, // per channel: space (IN) or data (OUT)
    input wire [5:0] i_total_done, // per channel: total length reached
    input wire i_frame_time_ok, // enough frame time remains
    input wire [23:0] i_flag_clr, // write-one-to-clear, 4 bits per channel
    input wire [23:0] i_flag_en, // interrupt enables, 4 bits per channel
    input wire i_bot_enable, // bulk-only automatic transport on
    output reg [5:0] o_xfer_execute, // execute bits
    output reg [23:0] o_flags, // sticky flags, 4 per channel
    output reg [17:0] o_result_code, // result code, 3 bits per channel
    output wire o_irq, // host interrupt
    output reg o_txn_start, // pulse: transaction to link
    output reg [2:0] o_txn_chan, // channel of current transaction
    output reg [1:0] o_txn_type, // token type
    output reg [6:0] o_txn_addr, // target address
    output reg [3:0] o_txn_ep, // target endpoint
    output reg [6:0] o_txn_len, // data length for setup
    output reg [63:0] o_txn_data, // setup payload
    input wire i_txn_done, // pulse: link finished
    input wire [1:0] i_txn_resp, // link answer code
    output reg [1:0] o_bot_phase // bulk-only transport phase
);
    // ==========================================================
    // reset synchroniser
    reg rst_s1_q;
    reg rst_s2_q;
    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end
    wire rst_n = rst_s2_q;

    // ==========================================================
    // helpers
    localparam ST_IDLE = 2'h0;
    localparam ST_CHECK = 2'h1;
    localparam ST_RUN = 2'h2;

    // next armed channel after last, round robin; the sum is kept four bits
    // wide so last + k cannot wrap past eight before the channel-count fold
    function [3:0] uhcs_pick;
        input [5:0] armed;
        input [2:0] last;
        integer k;
        reg [3:0] sum;
        reg [2:0] idx;
        reg found;
        begin
            uhcs_pick = 4'h0;
            found = 1'b0;
            for (k = 1; k <= `UHCS_NCH; k = k + 1) begin
                sum = {1'b0, last} + k[3:0];
                if (sum >= `UHCS_NCH_W)
                    sum = sum - `UHCS_NCH_W;
                idx = sum[2:0];
                if (!found && armed[idx]) begin
                    found = 1'b1;
                    uhcs_pick = {1'b1, idx};
                end
            end
        end
    endfunction

    // feasibility: setup needs frame time; in/out need fifo and frame time
    function uhcs_feasible;
        input [1:0] tt;
        input fifo_ok;
        input time_ok;
        begin
            if (tt == `UHCS_TT_SETUP)
                uhcs_feasible = time_ok;
            else
                uhcs_feasible = time_ok & fifo_ok;
        end
    endfunction

    // ==========================================================
    // scheduler state
    reg [1:0] state_q;
    reg [2:0] last_q;
    reg [2:0] cur_q;
    reg [11:0] retry_q;

    wire [3:0] pick = uhcs_pick(o_xfer_execute, last_q);
    wire [1:0] cur_tt = i_tt_sel[cur_q*2 +: 2];
    wire cur_fifo = i_fifo_ready[cur_q];
    wire cur_ok = uhcs_feasible(cur_tt, cur_fifo, i_frame_time_ok);
    wire [1:0] cur_retry = retry_q[cur_q*2 +: 2];
    wire fail = (i_txn_resp == `UHCS_RSP_NONE);
    wire last_fail = fail && (cur_retry + 2'h1 == `UHCS_RETRY_MAX);

    // events raised by the running transaction, in the current channel's bits only
    reg [23:0] flag_set;
    reg [5:0] exec_hw_clr;
    always @* begin
        flag_set = 24'h000000;
        exec_hw_clr = 6'h00;
        if (state_q == ST_RUN && i_txn_done) begin
            if (i_txn_resp == `UHCS_RSP_ACK)
                flag_set[cur_q*4 + `UHCS_F_ACK] = 1'b1;
            if (fail)
                flag_set[cur_q*4 + `UHCS_F_ERR] = 1'b1;
            if (last_fail || i_txn_resp == `UHCS_RSP_STALL) begin
                flag_set[cur_q*4 + `UHCS_F_COND] = 1'b1;
                exec_hw_clr[cur_q] = 1'b1;
            end
            if (i_txn_resp == `UHCS_RSP_ACK && i_total_done[cur_q])
                flag_set[cur_q*4 + `UHCS_F_TOTAL] = 1'b1;
        end
    end

    // ==========================================================
    // execute bits and sticky flags; set wins over clear
    genvar g;
    generate
        for (g = 0; g < `UHCS_NCH; g = g + 1) begin : g_ch
            always @(posedge i_ref_clk or negedge rst_n) begin
                if (!rst_n) begin
                    o_xfer_execute[g] <= 1'b0;
                end else if (i_ce) begin
                    if (i_exec_set[g])
                        o_xfer_execute[g] <= 1'b1;
                    else if (i_exec_clr[g] || exec_hw_clr[g])
                        o_xfer_execute[g] <= 1'b0;
                end
            end
            always @(posedge i_ref_clk or negedge rst_n) begin
                if (!rst_n) begin
                    o_flags[g*4 +: 4] <= 4'h0;
                end else if (i_ce) begin
                    o_flags[g*4 +: 4] <= (o_flags[g*4 +: 4] & ~i_flag_clr[g*4 +: 4])
                        | flag_set[g*4 +: 4];
                end
            end
        end
    endgenerate

    assign o_irq = |(o_flags & i_flag_en);

    // ==========================================================
    // scheduler: select, check, run one transaction
    always @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            last_q <= 3'h5;
            cur_q <= 3'h0;
            retry_q <= 12'h000;
            o_result_code <= 18'h00000;
            o_txn_start <= 1'b0;
            o_txn_chan <= 3'h0;
            o_txn_type <= 2'h0;
            o_txn_addr <= 7'h00;
            o_txn_ep <= 4'h0;
            o_txn_len <= 7'h00;
            o_txn_data <= 64'h0;
            o_bot_phase <= `UHCS_BOT_CBW;
        end else if (i_ce) begin
            o_txn_start <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (pick[3]) begin
                        cur_q <= pick[2:0];
                        state_q <= ST_CHECK;
                    end
                end
                ST_CHECK: begin
                    last_q <= cur_q;
                    if (!o_xfer_execute[cur_q]) begin
                        state_q <= ST_IDLE;
                    end else if (cur_ok) begin
                        // only a feasible transfer is launched
                        o_txn_start <= 1'b1;
                        o_txn_chan <= cur_q;
                        o_txn_type <= cur_tt;
                        if (cur_q == `UHCS_CH_CTRL) begin
                            o_txn_addr <= i_func_addr;
                            o_txn_ep <= `UHCS_EP0;
                            o_txn_len <= `UHCS_SETUP_LEN;
                            o_txn_data <= i_setup_bytes;
                        end else begin
                            o_txn_addr <= 7'h00;
                            o_txn_ep <= 4'h0;
                            o_txn_len <= 7'h00;
                            o_txn_data <= 64'h0;
                        end
                        state_q <= ST_RUN;
                    end else begin
                        state_q <= ST_IDLE; // try the next armed channel
                    end
                end
                ST_RUN: begin
                    if (i_txn_done) begin
                        state_q <= ST_IDLE;
                        case (i_txn_resp)
                            `UHCS_RSP_ACK: begin
                                retry_q[cur_q*2 +: 2] <= 2'h0;
                                o_result_code[cur_q*3 +: 3] <= `UHCS_RC_OK;
                            end
                            `UHCS_RSP_NAK: begin
                                retry_q[cur_q*2 +: 2] <= 2'h0;
                                o_result_code[cur_q*3 +: 3] <= `UHCS_RC_NAK;
                            end
                            `UHCS_RSP_STALL: begin
                                retry_q[cur_q*2 +: 2] <= 2'h0;
                                o_result_code[cur_q*3 +: 3] <= `UHCS_RC_STALL;
                            end
                            default: begin
                                o_result_code[cur_q*3 +: 3] <= `UHCS_RC_RETRY;
                                retry_q[cur_q*2 +: 2] <= last_fail ? 2'h0
                                    : cur_retry + 2'h1;
                            end
                        endcase
                        // bulk-only transport steps on an acknowledged phase end
                        if (cur_q == `UHCS_CH_BOT && i_bot_enable
                                && i_txn_resp == `UHCS_RSP_ACK) begin
                            case (o_bot_phase)
                                `UHCS_BOT_CBW: o_bot_phase <= `UHCS_BOT_DATA;
                                `UHCS_BOT_DATA: begin
                                    if (i_total_done[cur_q])
                                        o_bot_phase <= `UHCS_BOT_CSW;
                                end
                                `UHCS_BOT_CSW: o_bot_phase <= `UHCS_BOT_CBW;
                                default: o_bot_phase <= `UHCS_BOT_CBW;
                            endcase
                        end
                        if (cur_q == `UHCS_CH_BOT && exec_hw_clr[cur_q])
                            o_bot_phase <= `UHCS_BOT_CBW;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
            // with automatic transport off the phase rests at command stage
            if (!i_bot_enable)
                o_bot_phase <= `UHCS_BOT_CBW;
        end
    end
endmodule // uhcs_scheduler

// File: uhcs_defines.vh
`ifndef UHCS_DEFINES_VH
`define UHCS_DEFINES_VH
// ==========================================================
// channel indices and counts
`define UHCS_NCH 6
`define UHCS_NCH_W 4'h6
`define UHCS_CH_CTRL 3'h0
`define UHCS_CH_BOT 3'h1
// ==========================================================
// transaction types
`define UHCS_TT_SETUP 2'h0
`define UHCS_TT_IN 2'h1
`define UHCS_TT_OUT 2'h2
// ==========================================================
// link answers
`define UHCS_RSP_ACK 2'h0
`define UHCS_RSP_NAK 2'h1
`define UHCS_RSP_STALL 2'h2
`define UHCS_RSP_NONE 2'h3
// ==========================================================
// result codes
`define UHCS_RC_OK 3'h0
`define UHCS_RC_STALL 3'h1
`define UHCS_RC_RETRY 3'h2
`define UHCS_RC_NAK 3'h3
// ==========================================================
// retry limit and setup length
`define UHCS_RETRY_MAX 2'h3
`define UHCS_SETUP_LEN 7'h08
`define UHCS_EP0 4'h0
// ==========================================================
// flag bit positions
`define UHCS_F_TOTAL 0
`define UHCS_F_ACK 1
`define UHCS_F_ERR 2
`define UHCS_F_COND 3
// ==========================================================
// bulk-only phases
`define UHCS_BOT_CBW 2'h0
`define UHCS_BOT_DATA 2'h1
`define UHCS_BOT_CSW 2'h2
`endif

// File: uhcs_link_model.sv
// ==========================================================
// downstream device model: answers each transaction after a delay
module uhcs_link_model (
    input wire logic i_clk, // system clock
    input wire logic i_rst_n, // reset, active low
    input wire logic i_start, // transaction launch
    input wire logic [1:0] i_resp_sel, // answer commanded by bench
    input wire logic [3:0] i_delay, // cycles before the answer
    output logic o_done, // answer pulse
    output logic [1:0] o_resp // answer code
);
    timeunit 1ns;
    timeprecision 1ps;
    logic busy;
    logic [3:0] cnt;
    // one answer per launch; code toggles away from done so stale reads show up
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            busy <= 0;
            cnt <= 0;
            o_done <= 0;
            o_resp <= 2'h0;
        end else if (i_start) begin
            busy <= 1;
            cnt <= i_delay;
            o_done <= 0;
            o_resp <= ~o_resp;
        end else if (busy && cnt == 0) begin
            busy <= 0;
            o_done <= 1;
            o_resp <= i_resp_sel;
        end else begin
            cnt <= cnt - 1;
            o_done <= 0;
            o_resp <= ~o_resp;
        end
    end
endmodule // uhcs_link_model

// File: uhcs_scheduler_props.sv
// ==========================================================
// port-level checks of the scheduler
module uhcs_scheduler_props (
    input wire i_ref_clk, // clock
    input wire i_rst_n, // reset, active low
    input wire i_ce, // clock enable
    input wire [5:0] i_exec_set, // execute set
    input wire [63:0] i_setup_bytes, // setup bytes
    input wire i_frame_time_ok, // frame time left
    input wire [23:0] i_flag_clr, // flag clear
    input wire [23:0] i_flag_en, // flag enables
    input wire [5:0] o_xfer_execute, // execute bits
    input wire [23:0] o_flags, // flags
    input wire [17:0] o_result_code, // result codes
    input wire o_irq, // interrupt
    input wire o_txn_start, // launch
    input wire [2:0] o_txn_chan, // channel
    input wire [3:0] o_txn_ep, // endpoint
    input wire [6:0] o_txn_len, // length
    input wire [63:0] o_txn_data, // payload
    input wire i_txn_done, // link done
    input wire [1:0] i_txn_resp // link answer
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    a_start_single_pulse: assert property (o_txn_start |=> !o_txn_start)
        else $error("launch pulse longer than one cycle");
    a_start_needs_exec: assert property (o_txn_start |-> o_xfer_execute[o_txn_chan])
        else $error("launch on a channel that is not armed");
    a_exec_set_arms: assert property (i_ce && i_exec_set[0] |=> o_xfer_execute[0])
        else $error("execute set not taken");
    a_setup_frame_time: assert property (o_txn_start && o_txn_chan == 3'h0
        |-> $past(i_frame_time_ok))
        else $error("setup launched without frame time");
    a_setup_packet_shape: assert property (o_txn_start && o_txn_chan == 3'h0
        |-> o_txn_ep == 4'h0 && o_txn_len == 7'h08 && o_txn_data == i_setup_bytes)
        else $error("setup packet fields wrong");
    a_ack_sets_flag: assert property (i_ce && i_txn_done && i_txn_resp == 2'h0
        && o_txn_chan == 3'h0 |=> o_flags[1])
        else $error("acknowledge flag not raised");
    a_retry_code_err: assert property (i_ce && i_txn_done && i_txn_resp == 2'h3
        && o_txn_chan == 3'h0 |=> o_flags[2] && o_result_code[2:0] == 3'h2)
        else $error("retry code or error flag missing");
    a_flag_stays_set: assert property (i_ce && o_flags[1] && !i_flag_clr[1] |=> o_flags[1])
        else $error("acknowledge flag dropped by itself");
    a_irq_from_flags: assert property (o_irq == |(o_flags & i_flag_en))
        else $error("interrupt does not match enabled flags");
endmodule // uhcs_scheduler_props
bind uhcs_scheduler uhcs_scheduler_props uhcs_scheduler_props_inst (.i_ref_clk, .i_rst_n,
    .i_ce, .i_exec_set, .i_setup_bytes, .i_frame_time_ok, .i_flag_clr, .i_flag_en,
    .o_xfer_execute, .o_flags, .o_result_code, .o_irq, .o_txn_start, .o_txn_chan,
    .o_txn_ep, .o_txn_len, .o_txn_data, .i_txn_done, .i_txn_resp);

// File: uhcs_scheduler_bench.sv
// ==========================================================
// testbench
module uhcs_scheduler_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst_n = 0, frame_ok = 0, bot_en = 0, done;
    logic [5:0] exec_set = 0, exec_clr = 0, fifo_rdy = 6'h3F, tot_done = 0, xe;
    logic [23:0] flag_clr = 0, flags;
    logic [17:0] rc;
    logic [1:0] resp, resp_sel = 0, phase, ttype;
    logic [3:0] dly = 0, ep;
    logic [2:0] ch, c1, c2;
    logic [6:0] len, addr;
    logic [63:0] data;
    logic start, irq;
    int failures = 0, samples_checked = 0;
    uhcs_scheduler uhcs_scheduler_inst (.i_ref_clk(clk), .i_rst_n(rst_n), .i_ce(1'b1),
        .i_exec_set(exec_set), .i_exec_clr(exec_clr), .i_tt_sel(12'h058),
        .i_func_addr(7'h2A), .i_setup_bytes(64'h0807060504030201), .i_fifo_ready(fifo_rdy),
        .i_total_done(tot_done), .i_frame_time_ok(frame_ok), .i_flag_clr(flag_clr),
        .i_flag_en(24'h000002), .i_bot_enable(bot_en), .o_xfer_execute(xe), .o_flags(flags),
        .o_result_code(rc), .o_irq(irq), .o_txn_start(start), .o_txn_chan(ch),
        .o_txn_type(ttype), .o_txn_addr(addr), .o_txn_ep(ep), .o_txn_len(len),
        .o_txn_data(data), .i_txn_done(done), .i_txn_resp(resp), .o_bot_phase(phase));
    uhcs_link_model uhcs_link_model_inst (.i_clk(clk), .i_rst_n(rst_n), .i_start(start),
        .i_resp_sel(resp_sel), .i_delay(dly), .o_done(done), .o_resp(resp));
    // clock
    always #10 clk = ~clk;
    // ==========================================================
    // tasks
    task chk(input [63:0] got, input [63:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task pulse(input [5:0] s, input [5:0] c, input [23:0] f);
        @(negedge clk);
        exec_set = s; exec_clr = c; flag_clr = f;
        @(negedge clk);
        exec_set = 0; exec_clr = 0; flag_clr = 0;
    endtask
    task txn(input [1:0] r, output [2:0] got);
        int n;
        resp_sel = r;
        for (n = 0; n < 60 && start !== 1'b1; n++) @(negedge clk);
        chk(start, 1);
        got = ch;
        for (n = 0; n < 30 && done !== 1'b1; n++) @(negedge clk);
        @(negedge clk);
    endtask
    task tally_and_finish;
        $display("failures %0d samples_checked %0d", failures, samples_checked);
        if (failures == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // ==========================================================
    // tests
    initial begin
        repeat (4) @(negedge clk);
        rst_n = 1;
        repeat (3) @(negedge clk);
        // setup held back while frame time is short, then sent whole
        pulse(6'h01, 0, 0);
        repeat (20) begin
            @(negedge clk);
            chk(start, 0);
        end
        frame_ok = 1;
        txn(2'h0, c1);
        chk(c1, 0);
        chk({ep, len, addr}, {4'h0, 7'h08, 7'h2A});
        chk(data, 64'h0807060504030201);
        chk({flags[3:0], rc[2:0], irq}, {4'h2, 3'h0, 1'b1});
        // three missing answers in a row end the transfer; the still armed
        // control channel is relaunched at once, so the first retry starts in the pulse
        pulse(6'h01, 0, 24'hFFFFFF);
        dly = 3;
        repeat (3) begin
            txn(2'h3, c1);
            chk({flags[2], rc[2:0]}, {1'b1, 3'h2});
        end
        chk({xe[0], flags[3]}, 2'b01);
        // two armed IN channels alternate; a full fifo skips its channel
        pulse(6'h0C, 0, 24'hFFFFFF);
        repeat (2) begin
            txn(2'h1, c1);
            txn(2'h1, c2);
            chk(c2, c1 == 3'h2 ? 3'h3 : 3'h2);
            chk(ttype, 2'h1);
        end
        chk(phase, 0);
        fifo_rdy[2] = 0;
        repeat (2) begin
            txn(2'h1, c1);
            chk(c1, 3);
        end
        pulse(0, 6'h0C, 0);
        repeat (20) @(negedge clk);
        // bulk-only transport walks command, data and status by itself
        bot_en = 1;
        dly = 0;
        pulse(6'h02, 0, 0);
        txn(2'h0, c1);
        chk({c1, phase}, {3'h1, 2'h1});
        tot_done[1] = 1;
        txn(2'h0, c1);
        chk(phase, 2);
        txn(2'h0, c1);
        // back at the command stage: the only point where the target may change
        chk(phase, 0);
        tally_and_finish;
    end
    // watchdog sized well beyond the sequence length
    initial begin
        #200000;
        failures++;
        tally_and_finish;
    end
endmodule // uhcs_scheduler_bench
